// >>> mdd_consts.svh
/*
  constants of the motor driver diagnostic register group: offsets, field positions, reset values
  assumes: included by bare name from the back-emf averaging module and the register module
*/
`ifndef MDD_CONSTS_SVH
`define MDD_CONSTS_SVH

// register indices (read at the even index, write at the odd one)
`define MDD_IDX_BACKEMF_RD    8'h08
`define MDD_IDX_BACKEMF_WR    8'h09
`define MDD_IDX_STEP_RD       8'h0A
`define MDD_IDX_STEP_WR       8'h0B
`define MDD_IDX_OCP_RD        8'h0C
`define MDD_IDX_OCP_WR        8'h0D
`define MDD_IDX_FAULT_RD      8'h0E
`define MDD_IDX_FAULT_WR      8'h0F

// back-emf register fields
`define MDD_BACKEMF_READING_SEL_BIT      11
`define MDD_BACKEMF_READING_GAIN_HI      10
`define MDD_BACKEMF_READING_GAIN_LO      8
`define MDD_BACKEMF_READING_GAIN_RST     3'h3
`define MDD_BACKEMF_READING_AVG_SAMPLES  16

// step position register
`define MDD_STEP_RST          12'h0510
`define MDD_STEP_POS_RST      7'h10

// overcurrent register
`define MDD_OCP_RSVD          8'h55
`define MDD_OCP_AH_BIT        3
`define MDD_OCP_AL_BIT        2
`define MDD_OCP_BH_BIT        1
`define MDD_OCP_BL_BIT        0

// fault register
`define MDD_FLT_STALL_BIT     9
`define MDD_FLT_OLA_BIT       8
`define MDD_FLT_OLB_BIT       7
`define MDD_FLT_OCP_BIT       6
`define MDD_FLT_OTS_BIT       5
`define MDD_FLT_OTW_BIT       4
`define MDD_FLT_OVP_BIT       3
`define MDD_FLT_MOTOR_SUPPLY_LOW_FLAG_BIT     2
`define MDD_FLT_LOGIC_SUPPLY_LOW_FLAG_BIT     1
`define MDD_FLT_SUM_BIT       0
`define MDD_FLT_LATCH_RST     9'h001

`endif

// >>> mdd_pkg.sv
/*
  types of the motor driver diagnostic register group
  assumes: nothing
*/
package mdd_pkg;

  // hardware fault events, one-cycle or level, active high
  typedef struct packed {
    logic stall;
    logic open_load_a;
    logic open_load_b;
    logic thermal_shutdown;
    logic thermal_warning;
    logic overvoltage;
    logic motor_supply_low;
    logic logic_supply_low;
  } mdd_fault_ev_s;

  // back-emf sample input
  typedef struct packed {
    logic       valid;
    logic [7:0] value;
  } mdd_backemf_reading_smp_s;

  typedef enum logic [1:0] {
    MDD_RD_IDLE = 2'b00,
    MDD_RD_RESP = 2'b01
  } mdd_rd_state_e;

endpackage

// >>> mdd_backemf_reading_avg.sv
/*
  back-emf averaging: sums samples in blocks of 16, restarting after each block, and outputs either
  the average or the most recent sample, registered
  assumes: one sample per valid pulse, taken at a zero-current step
*/
`timescale 1ns/1ns
`include "mdd_consts.svh"

module mdd_backemf_reading_avg #(
  parameter int SAMPLES = `MDD_BACKEMF_READING_AVG_SAMPLES
) (
  input  wire logic                  core_clk,
  input  wire logic                  rst_n,
  input  wire mdd_pkg::mdd_backemf_reading_smp_s smp,
  input  wire logic                  realtime_sel,
  output logic [7:0]                 value
);

  localparam int CW = $clog2(SAMPLES);
  localparam int SW = 8 + CW;

  logic [CW-1:0] cnt;
  logic [SW-1:0] acc;
  logic [7:0]    avg;
  logic [7:0]    last;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt  <= '0;
      acc  <= '0;
      avg  <= 8'h00;
      last <= 8'h00;
    end else if (smp.valid) begin
      last <= smp.value;
      cnt  <= CW'(cnt + 1'b1);
      if (cnt == CW'(SAMPLES - 1)) begin
        avg <= 8'((acc + SW'(smp.value)) >> CW);
        acc <= '0;
      end else begin
        acc <= SW'(acc + SW'(smp.value));
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n)
      value <= 8'h00;
    else
      value <= realtime_sel ? last : avg;
  end

endmodule

// >>> mdd_flag_latch.sv
/*
  bank of sticky flags: set by hardware events, cleared by write-one
  assumes: set and clear are synchronous to core_clk
*/
`timescale 1ns/1ns

module mdd_flag_latch #(
  parameter int          N   = 4,
  parameter logic [N-1:0] RST = '0
) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic [N-1:0] set,
  input  wire logic [N-1:0] clr,
  output logic      [N-1:0] flags
);

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_flag
      // set wins over a simultaneous clear so no event is lost
      always_ff @(posedge core_clk) begin
        if (!rst_n)
          flags[i] <= RST[i];
        else if (set[i])
          flags[i] <= 1'b1;
        else if (clr[i])
          flags[i] <= 1'b0;
      end
    end
  endgenerate

endmodule

// >>> mdd_diag_regs.sv
/*
  diagnostic register group of a stepper motor driver: back-emf settings and
  result, step-table position, overcurrent flags, fault status and fault pin,
  reached over an axi4-lite slave
  assumes: single clock core_clk, synchronous active-low rst_n that is also
  driven by supply start-up and the external reset pin; events synchronous
*/
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "mdd_consts.svh"

module mdd_diag_regs (
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  // axi4-lite slave
  input  wire logic [7:0]             s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [7:0]             s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // hardware events
  input  wire logic [3:0]             ocp_event,
  input  wire mdd_pkg::mdd_fault_ev_s fault_event,
  input  wire mdd_pkg::mdd_backemf_reading_smp_s backemf_reading_sample,
  // block outputs
  output logic                        backemf_mode_select,
  output logic [2:0]                  backemf_gain,
  output logic [6:0]                  step_table_position,
  output logic                        fault_output_pin_n
);

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // write channel capture
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_fire;
  logic [7:0]  wr_idx;
  logic        wr_hit;
  logic        wr_lo;
  logic        wr_hi;

  // register state
  logic [4:0]  step_rsvd;
  logic [3:0]  ocp_flags;
  logic [3:0]  ocp_clr;
  logic [8:0]  flt_flags;
  logic [8:0]  flt_set;
  logic [8:0]  flt_clr;
  logic [7:0]  backemf_reading_value;
  logic        ocp_summary;
  logic        fault_summary;
  logic [11:0] rd_word;
  logic [7:0]  rd_idx;
  logic        rd_hit;

  // aw and w are taken independently, in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  assign wr_fire = aw_held && w_held;
  assign wr_idx  = {2'b00, aw_addr[7:2]};
  // only the odd index of each pair accepts writes
  assign wr_hit  = (aw_addr[1:0] == 2'b00) && wr_idx[0] && (wr_idx >= `MDD_IDX_BACKEMF_WR)
                   && (wr_idx <= `MDD_IDX_FAULT_WR);
  assign wr_lo   = w_strb[0];
  assign wr_hi   = w_strb[1];

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // back-emf settings
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      backemf_mode_select <= 1'b0;
      backemf_gain        <= `MDD_BACKEMF_READING_GAIN_RST;
    end else if (wr_fire && wr_idx == `MDD_IDX_BACKEMF_WR && wr_hi) begin
      backemf_mode_select <= w_data[`MDD_BACKEMF_READING_SEL_BIT];
      backemf_gain        <= w_data[`MDD_BACKEMF_READING_GAIN_HI:`MDD_BACKEMF_READING_GAIN_LO];
    end
  end

  mdd_backemf_reading_avg u_backemf_reading_avg (
    .core_clk     (core_clk),
    .rst_n        (rst_n),
    .smp          (backemf_reading_sample),
    .realtime_sel (backemf_mode_select),
    .value        (backemf_reading_value)
  );

  // step position, reserved upper bits kept as writable storage
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      step_table_position <= `MDD_STEP_POS_RST;
      step_rsvd           <= 5'(`MDD_STEP_RST >> 7);
    end else if (wr_fire && wr_idx == `MDD_IDX_STEP_WR) begin
      if (wr_lo) begin
        step_table_position <= w_data[6:0];
      end
      step_rsvd <= {wr_hi ? w_data[11:8] : step_rsvd[4:1], wr_lo ? w_data[7] : step_rsvd[0]};
    end
  end

  // overcurrent flags, write-one-to-clear
  assign ocp_clr = (wr_fire && wr_idx == `MDD_IDX_OCP_WR && wr_lo) ? w_data[3:0] : 4'h0;

  mdd_flag_latch #(
    .N   (4),
    .RST (4'h0)
  ) u_ocp_flags (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .set      (ocp_event),
    .clr      (ocp_clr),
    .flags    (ocp_flags)
  );

  assign ocp_summary = |ocp_flags;

  // fault flags at bits 9..1, summary bits excluded so writes there do nothing
  assign flt_set = {fault_event.stall,
                    fault_event.open_load_a, fault_event.open_load_b,
                    1'b0,
                    fault_event.thermal_shutdown,
                    fault_event.thermal_warning,
                    fault_event.overvoltage,
                    fault_event.motor_supply_low,
                    fault_event.logic_supply_low};
  assign flt_clr = (wr_fire && wr_idx == `MDD_IDX_FAULT_WR)
                   ? ({wr_hi ? w_data[9:8] : 2'b00, wr_lo ? w_data[7:1] : 7'h00} & 9'h1DF) : 9'h000;

  // logic supply flag resets set, since every device reset passes through rst_n
  mdd_flag_latch #(
    .N   (9),
    .RST (`MDD_FLT_LATCH_RST)
  ) u_flt_flags (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .set      (flt_set),
    .clr      (flt_clr),
    .flags    (flt_flags)
  );

  // undervoltage flags excluded from the summary
  assign fault_summary = flt_flags[8] | flt_flags[7] | flt_flags[6] | flt_flags[4] | flt_flags[3]
                         | flt_flags[2] | ocp_summary;

  // pin is active low; registered so the bit and the pin move together
  logic fault_reg;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      fault_reg          <= 1'b0;
      fault_output_pin_n <= 1'b1;
    end else begin
      fault_reg          <= fault_summary;
      fault_output_pin_n <= !fault_summary;
    end
  end

  // read path: answer one cycle after the address is taken
  assign rd_idx = {2'b00, s_axi_araddr[7:2]};
  assign rd_hit = (s_axi_araddr[1:0] == 2'b00) && !rd_idx[0] && (rd_idx >= `MDD_IDX_BACKEMF_RD)
                  && (rd_idx <= `MDD_IDX_FAULT_RD);
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    case (rd_idx)
      `MDD_IDX_BACKEMF_RD: rd_word = {backemf_mode_select, backemf_gain, backemf_reading_value};
      `MDD_IDX_STEP_RD:    rd_word = {step_rsvd, step_table_position};
      `MDD_IDX_OCP_RD:     rd_word = {`MDD_OCP_RSVD, ocp_flags};
      `MDD_IDX_FAULT_RD:   rd_word = {2'b00, flt_flags[8:6], ocp_summary, flt_flags[4:0], fault_reg};
      default:             rd_word = 12'h000;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_hit ? {20'h0_0000, rd_word} : 32'h0000_0000;
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // assertions

  sequence s_wr_fault_clr_one;
    wr_fire && wr_idx == `MDD_IDX_FAULT_WR && wr_lo && w_data[`MDD_FLT_LOGIC_SUPPLY_LOW_FLAG_BIT];
  endsequence

  AST_LOGIC_SUPPLY_LOW_FLAG_RESET: assert property (@(posedge core_clk) !rst_n |=> flt_flags[0])
    else $error("logic supply flag not set after reset");
  AST_LOGIC_SUPPLY_LOW_FLAG_RELEASE: assert property (@(posedge core_clk) $rose(rst_n) |-> flt_flags[0])
    else $error("logic supply flag clear at reset release");
  AST_GAIN_RESET: assert property (@(posedge core_clk) !rst_n |=> backemf_gain == 3'h3 && !backemf_mode_select)
    else $error("back-emf settings wrong after reset");
  AST_STEP_RESET: assert property (@(posedge core_clk) !rst_n |=> step_table_position == 7'h10)
    else $error("step position wrong after reset");
  AST_OCP_SET: assert property (@(posedge core_clk) disable iff (!rst_n) ocp_event[3] |=> ocp_flags[3])
    else $error("bridge A high-side flag not set");
  AST_OCP_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
    ocp_flags[0] && !ocp_clr[0] |=> ocp_flags[0])
    else $error("overcurrent flag dropped without clear");
  AST_SUMMARY: assert property (@(posedge core_clk) disable iff (!rst_n) (|ocp_flags) |=> !fault_output_pin_n)
    else $error("overcurrent flag did not reach fault pin");
  AST_STALL_SET: assert property (@(posedge core_clk) disable iff (!rst_n)
    fault_event.stall |=> flt_flags[8] ##1 !fault_output_pin_n)
    else $error("stall did not reach fault pin");
  AST_W1C: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_wr_fault_clr_one ##0 !fault_event.logic_supply_low |=> !flt_flags[0])
    else $error("write one did not clear logic supply flag");
  AST_PIN_MIRROR: assert property (@(posedge core_clk) disable iff (!rst_n) fault_reg == !fault_output_pin_n)
    else $error("fault bit and pin disagree");
  AST_UV_NO_PIN: assert property (@(posedge core_clk) disable iff (!rst_n)
    (flt_flags[1:0] != 2'b00) && (flt_flags[8:2] & 7'h77) == 7'h00 && !ocp_summary |=> fault_output_pin_n)
    else $error("undervoltage drove the fault pin");

  // per-flag set checks: an event must be visible in its flag on the next cycle
  AST_OCP_AL_SET: assert property (@(posedge core_clk) disable iff (!rst_n) ocp_event[2] |=> ocp_flags[2])
    else $error("bridge A low-side flag not set");
  AST_OCP_BH_SET: assert property (@(posedge core_clk) disable iff (!rst_n) ocp_event[1] |=> ocp_flags[1])
    else $error("bridge B high-side flag not set");
  AST_OCP_BL_SET: assert property (@(posedge core_clk) disable iff (!rst_n) ocp_event[0] |=> ocp_flags[0])
    else $error("bridge B low-side flag not set");
  AST_OLA_SET: assert property (@(posedge core_clk) disable iff (!rst_n)
    fault_event.open_load_a |=> flt_flags[7])
    else $error("open load flag of first bridge not set");
  AST_OLB_SET: assert property (@(posedge core_clk) disable iff (!rst_n)
    fault_event.open_load_b |=> flt_flags[6])
    else $error("open load flag of second bridge not set");
  AST_OTS_SET: assert property (@(posedge core_clk) disable iff (!rst_n)
    fault_event.thermal_shutdown |=> flt_flags[4])
    else $error("thermal shutdown flag not set");
  AST_OTW_SET: assert property (@(posedge core_clk) disable iff (!rst_n)
    fault_event.thermal_warning |=> flt_flags[3])
    else $error("thermal warning flag not set");
  AST_OVP_SET: assert property (@(posedge core_clk) disable iff (!rst_n)
    fault_event.overvoltage |=> flt_flags[2])
    else $error("overvoltage flag not set");
  AST_MOTOR_SUPPLY_LOW_FLAG_SET: assert property (@(posedge core_clk) disable iff (!rst_n)
    fault_event.motor_supply_low |=> flt_flags[1])
    else $error("motor supply flag not set");
  AST_LOGIC_SUPPLY_LOW_FLAG_SET: assert property (@(posedge core_clk) disable iff (!rst_n)
    fault_event.logic_supply_low |=> flt_flags[0])
    else $error("logic supply flag not set");

  // bus answers: both responses come one cycle after the request is complete
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  sequence s_wr_backemf_reading;
    wr_fire && wr_idx == `MDD_IDX_BACKEMF_WR;
  endsequence

  AST_RD_ANSWER: assert property (@(posedge core_clk) disable iff (!rst_n) s_rd_taken |=> s_axi_rvalid)
    else $error("read answer missing");
  AST_WR_ANSWER: assert property (@(posedge core_clk) disable iff (!rst_n) wr_fire |=> s_axi_bvalid)
    else $error("write answer missing");
  AST_GAIN_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
    !s_axi_bvalid && !wr_fire |=> $stable(backemf_gain) && $stable(backemf_mode_select))
    else $error("back-emf settings changed without a write");
  AST_GAIN_WRITE: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_wr_backemf_reading ##0 wr_hi |=> backemf_gain == $past(w_data[10:8]))
    else $error("gain write did not land");
  AST_STEP_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
    !wr_fire |=> $stable(step_table_position))
    else $error("step position changed without a write");

endmodule

// >>> mdd_host_model.sv
/*
  host model: axi4-lite master that stands in for the controller reaching the
  diagnostic registers; the bench calls its tasks
  assumes: slave answers on its own handshakes, one access at a time
*/
`timescale 1ns/1ns

module mdd_host_model (
  input  wire logic        core_clk,
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  int timeouts = 0;

  initial begin
    awaddr = '0; awvalid = 1'b0; wdata = '0; wstrb = '0; wvalid = 1'b0;
    bready = 1'b0; araddr = '0; arvalid = 1'b0; rready = 1'b0;
  end

  // each channel is released only at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    int n;
    logic done;
    done = 1'b0;
    resp = 2'b11;
    @(posedge core_clk);
    awaddr <= a; wdata <= d; wstrb <= 4'hF;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (n = 0; n < 64 && !done; n++) begin
      @(posedge core_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        resp = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) timeouts++;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    int n;
    logic done;
    done = 1'b0;
    d = 'x;
    resp = 2'b11;
    @(posedge core_clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (n = 0; n < 64 && !done; n++) begin
      @(posedge core_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) timeouts++;
  endtask
endmodule

// >>> motor_driver_diag_registers_tb.sv
/*
  testbench of the diagnostic register group: register accesses through the
  host model, hardware events driven directly, results compared to expectations
  assumes: mdd_diag_regs and mdd_host_model compiled before it
*/
`timescale 1ns/1ns

module motor_driver_diag_registers_tb;
  logic                   core_clk = 1'b0;
  logic                   rst_n;
  logic [3:0]             ocp_event;
  mdd_pkg::mdd_fault_ev_s fault_event;
  mdd_pkg::mdd_backemf_reading_smp_s backemf_reading_sample;
  logic                   backemf_mode_select;
  logic [2:0]             backemf_gain;
  logic [6:0]             step_table_position;
  logic                   fault_output_pin_n;
  logic [7:0]             awaddr, araddr;
  logic [31:0]            wdata, rdata;
  logic [3:0]             wstrb;
  logic [1:0]             bresp, rresp;
  logic                   awvalid, awready, wvalid, wready, bvalid, bready;
  logic                   arvalid, arready, rvalid, rready;
  int                     err_count = 0;
  int                     compares = 0;

  always #5 core_clk = ~core_clk;

  mdd_host_model mdd_host_model_inst (
    .core_clk(core_clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));

  mdd_diag_regs mdd_diag_regs_inst (
    .core_clk(core_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ocp_event(ocp_event),
    .fault_event(fault_event), .backemf_reading_sample(backemf_reading_sample), .backemf_mode_select(backemf_mode_select),
    .backemf_gain(backemf_gain), .step_table_position(step_table_position),
    .fault_output_pin_n(fault_output_pin_n));

  task automatic final_report();
    if (err_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic hang_check();
    if (mdd_host_model_inst.timeouts != 0) begin
      err_count++;
      final_report();
    end
  endtask

  task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rexp);
    logic [1:0] r;
    mdd_host_model_inst.wr(a, d, r);
    hang_check();
    chk("bresp", {30'h0, r}, {30'h0, rexp});
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] rexp);
    logic [31:0] d;
    logic [1:0]  r;
    mdd_host_model_inst.rd(a, d, r);
    hang_check();
    chk("rresp", {30'h0, r}, {30'h0, rexp});
    chk("rdata", d, exp);
  endtask

  task automatic sample(input logic [7:0] v);
    @(posedge core_clk);
    backemf_reading_sample <= {1'b1, v};
    @(posedge core_clk);
    backemf_reading_sample <= '0;
  endtask

  initial begin
    int i;
    int pos;
    rst_n = 1'b0;
    ocp_event = '0;
    fault_event = '0;
    backemf_reading_sample = '0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    rdc(8'h20, 32'h0000_0300, 2'b00);
    rdc(8'h28, 32'h0000_0510, 2'b00);
    rdc(8'h30, 32'h0000_0550, 2'b00);
    rdc(8'h38, 32'h0000_0002, 2'b00);
    chk("fault_pin", {31'h0, fault_output_pin_n}, 32'h0000_0001);
    wrc(8'h3C, 32'h0000_0002, 2'b00);
    rdc(8'h38, 32'h0000_0000, 2'b00);
    // read address written to, write address read, unmapped place
    wrc(8'h20, 32'h0000_0FFF, 2'b10);
    rdc(8'h24, 32'h0000_0000, 2'b10);
    rdc(8'h40, 32'h0000_0000, 2'b10);
    rdc(8'h20, 32'h0000_0300, 2'b00);
    wrc(8'h24, 32'h0000_0FFF, 2'b00);
    chk("mode", {31'h0, backemf_mode_select}, 32'h0000_0001);
    chk("gain", {29'h0, backemf_gain}, 32'h0000_0007);
    sample(8'hA5);
    rdc(8'h20, 32'h0000_0FA5, 2'b00);
    wrc(8'h24, 32'h0000_0000, 2'b00);
    // two blocks, so the last completed one holds only this value
    repeat (32) sample(8'h40);
    rdc(8'h20, 32'h0000_0040, 2'b00);
    wrc(8'h2C, 32'h0000_007F, 2'b00);
    chk("step", {25'h0, step_table_position}, 32'h0000_007F);
    rdc(8'h28, 32'h0000_007F, 2'b00);
    for (i = 0; i < 4; i++) begin
      @(posedge core_clk);
      ocp_event[i] <= 1'b1;
      @(posedge core_clk);
      ocp_event <= '0;
      rdc(8'h30, 32'h0000_0550 | (32'h1 << i), 2'b00);
      rdc(8'h38, 32'h0000_0041, 2'b00);
      chk("fault_pin", {31'h0, fault_output_pin_n}, 32'h0000_0000);
      wrc(8'h34, 32'h1 << i, 2'b00);
      rdc(8'h30, 32'h0000_0550, 2'b00);
      rdc(8'h38, 32'h0000_0000, 2'b00);
    end
    // struct bit i: 0 logic supply .. 7 stall; bit 6 of the register skipped
    for (i = 0; i < 8; i++) begin
      pos = (i < 5) ? i + 1 : i + 2;
      @(posedge core_clk);
      fault_event[i] <= 1'b1;
      @(posedge core_clk);
      fault_event <= '0;
      rdc(8'h38, (32'h1 << pos) | ((i >= 2) ? 32'h1 : 32'h0), 2'b00);
      chk("fault_pin", {31'h0, fault_output_pin_n}, (i < 2) ? 32'h1 : 32'h0);
      wrc(8'h3C, 32'h1 << pos, 2'b00);
      rdc(8'h38, 32'h0000_0000, 2'b00);
    end
    wrc(8'h3C, 32'h0000_0FFF, 2'b00);
    rdc(8'h38, 32'h0000_0000, 2'b00);
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    rdc(8'h38, 32'h0000_0002, 2'b00);
    rdc(8'h28, 32'h0000_0510, 2'b00);
    final_report();
  end
endmodule
